// >>> verilog/serial_line_arbiter_timer.sv
// Function
// - running flag reads 1 while counter counts
// - overflow flag set on overflow, cleared by write
// - mode 00 resets and holds the counter
// - counter msb readable, cleared by control write
// - low count byte readable, cleared by write
// - select 0: half bus clock, fall to fall
// - select 0: done flag at second fall
// - select 1: half prescaler clock, starts on low
// - select 1: already low starts at once
// - select 1: stops on next rising edge
// - arbitration restarts count on transmit rise
// - sample line at 38h/08h, low means lost
// - lost flag forces transmit pin high
// - transmit low without seen low restarts
// - mode field 00 idle, 01 measure, 10 arbitrate
// - lost cleared by writing upper mode bit 0
// - done flag cleared by any control write
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module serial_line_arbiter_timer #(
   parameter int CNT_W = arb_timer_pkg::CNT_W
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [arb_timer_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [arb_timer_pkg::DATA_W-1:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [arb_timer_pkg::DATA_W-1:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_rxd,
   input wire logic i_internal_transmit_out,
   input wire logic i_presc_tick,
   output logic o_txd,
   output logic o_irq
);
   // bus slave
   logic wait_ff;
   logic [arb_timer_pkg::DATA_W-1:0] rdata_ff;
   logic acc;
   logic wr_ctrl;
   logic wr_sts;
   logic wr_mask;
   logic [7:0] nxt_rdata;

   // control and status
   arb_timer_pkg::ctrl_t ctrl_ff;
   arb_timer_pkg::state_t state_ff;
   arb_timer_pkg::state_t nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic ovf_ff;
   logic done_ff;
   logic lost_ff;
   logic [arb_timer_pkg::IRQ_W-1:0] sts_ff;
   logic [arb_timer_pkg::IRQ_W-1:0] mask_ff;
   arb_timer_pkg::events_t evt;
   logic irq_ff;
   logic txd_ff;

   // line sampling and rates
   logic rx_s1_ff;
   logic rx_s2_ff;
   logic rx_s3_ff;
   logic rx_lvl_ff;
   logic rx_old_ff;
   logic tx_old_ff;
   logic half_ff;
   logic presc_half_ff;
   logic sampled_ff;
   logic low_seen_ff;
   logic rx_fall;
   logic rx_rise;
   logic tx_rise;
   logic cnt_en;
   logic running;
   logic idle_mode;
   logic cnt_clear;
   logic tick_cnt;
   logic sample_hit;
   logic arb_abort;
   logic [CNT_W-1:0] sample_pt;

   assign acc = (i_avs_read || i_avs_write) && !wait_ff;
   assign wr_ctrl = acc && i_avs_write && i_avs_byteenable[0] && i_avs_address == arb_timer_pkg::OFS_CONTROL;
   assign wr_sts = acc && i_avs_write && i_avs_byteenable[0] && i_avs_address == arb_timer_pkg::OFS_IRQ_STATUS;
   assign wr_mask = acc && i_avs_write && i_avs_byteenable[0] && i_avs_address == arb_timer_pkg::OFS_IRQ_MASK;

   always_comb begin
      nxt_rdata = 8'h00;
      unique case (i_avs_address)
         arb_timer_pkg::OFS_CONTROL: begin
            nxt_rdata[arb_timer_pkg::BIT_MODE_HIGH] = ctrl_ff.mode[1];
            nxt_rdata[arb_timer_pkg::BIT_MODE_LOW] = ctrl_ff.mode[0];
            nxt_rdata[arb_timer_pkg::BIT_LOST] = lost_ff;
            nxt_rdata[arb_timer_pkg::BIT_CLK_SEL] = ctrl_ff.clk_sel;
            nxt_rdata[arb_timer_pkg::BIT_DONE] = done_ff;
            nxt_rdata[arb_timer_pkg::BIT_RUN] = running;
            nxt_rdata[arb_timer_pkg::BIT_OVF] = ovf_ff;
            nxt_rdata[arb_timer_pkg::BIT_MSB] = cnt_ff[CNT_W-1];
         end
         arb_timer_pkg::OFS_COUNT: nxt_rdata = cnt_ff[7:0];
         arb_timer_pkg::OFS_IRQ_STATUS: nxt_rdata = {5'h00, sts_ff};
         arb_timer_pkg::OFS_IRQ_MASK: nxt_rdata = {5'h00, mask_ff};
         default: nxt_rdata = 8'h00;
      endcase
   end

   // one wait cycle: read data is latched while waitrequest is still high
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         wait_ff <= 1'b1;
         rdata_ff <= '0;
      end else if ((i_avs_read || i_avs_write) && wait_ff) begin
         wait_ff <= 1'b0;
         rdata_ff <= {24'h000000, nxt_rdata};
      end else begin
         wait_ff <= 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         ctrl_ff <= '0;
      end else if (wr_ctrl) begin
         ctrl_ff.mode <= arb_timer_pkg::mode_t'(i_avs_writedata[arb_timer_pkg::BIT_MODE_HIGH:arb_timer_pkg::BIT_MODE_LOW]);
         ctrl_ff.clk_sel <= i_avs_writedata[arb_timer_pkg::BIT_CLK_SEL];
      end
   end

   // receive pin: a change counts once stages two and three agree
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         rx_s1_ff <= 1'b1;
         rx_s2_ff <= 1'b1;
         rx_s3_ff <= 1'b1;
         rx_lvl_ff <= 1'b1;
         rx_old_ff <= 1'b1;
         tx_old_ff <= 1'b1;
      end else begin
         rx_s1_ff <= i_rxd;
         rx_s2_ff <= rx_s1_ff;
         rx_s3_ff <= rx_s2_ff;
         if (rx_s2_ff == rx_s3_ff) begin
            rx_lvl_ff <= rx_s3_ff;
         end
         rx_old_ff <= rx_lvl_ff;
         tx_old_ff <= i_internal_transmit_out;
      end
   end

   assign rx_fall = rx_old_ff && !rx_lvl_ff;
   assign rx_rise = !rx_old_ff && rx_lvl_ff;
   assign tx_rise = i_internal_transmit_out && !tx_old_ff;

   // half-rate enables for either clock source
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         half_ff <= 1'b0;
         presc_half_ff <= 1'b0;
      end else begin
         half_ff <= !half_ff;
         if (i_presc_tick) begin
            presc_half_ff <= !presc_half_ff;
         end
      end
   end

   assign cnt_en = ctrl_ff.clk_sel ? (i_presc_tick && presc_half_ff) : half_ff;
   assign running = state_ff == arb_timer_pkg::ST_COUNT || state_ff == arb_timer_pkg::ST_ARB_CNT;
   assign idle_mode = ctrl_ff.mode == arb_timer_pkg::MODE_IDLE || ctrl_ff.mode == arb_timer_pkg::MODE_RESERVED;
   assign sample_pt = ctrl_ff.clk_sel ? arb_timer_pkg::SAMPLE_PRESC_CLK : arb_timer_pkg::SAMPLE_BUS_CLK;
   assign sample_hit = state_ff == arb_timer_pkg::ST_ARB_CNT && cnt_ff == sample_pt && !sampled_ff;
   assign arb_abort = state_ff == arb_timer_pkg::ST_ARB_CNT && !i_internal_transmit_out && !low_seen_ff;
   assign tick_cnt = running && cnt_en;
   assign cnt_clear = idle_mode || wr_ctrl || tx_rise || arb_abort;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         arb_timer_pkg::ST_IDLE: nxt_state = state_ff;
         arb_timer_pkg::ST_ARMED: begin
            if (ctrl_ff.clk_sel ? !rx_lvl_ff : rx_fall) begin
               nxt_state = arb_timer_pkg::ST_COUNT;
            end
         end
         arb_timer_pkg::ST_COUNT: begin
            if (ctrl_ff.clk_sel ? rx_rise : rx_fall) begin
               nxt_state = arb_timer_pkg::ST_STOP;
            end
         end
         arb_timer_pkg::ST_STOP: nxt_state = state_ff;
         arb_timer_pkg::ST_ARB_WAIT: begin
            if (tx_rise) begin
               nxt_state = arb_timer_pkg::ST_ARB_CNT;
            end
         end
         arb_timer_pkg::ST_ARB_CNT: begin
            if (arb_abort && !tx_rise) begin
               nxt_state = arb_timer_pkg::ST_ARB_WAIT;
            end
         end
      endcase
   end

   // a control write re-arms the selected mode from scratch
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_ff <= arb_timer_pkg::ST_IDLE;
      end else if (wr_ctrl) begin
         unique case (arb_timer_pkg::mode_t'(i_avs_writedata[arb_timer_pkg::BIT_MODE_HIGH:arb_timer_pkg::BIT_MODE_LOW]))
            arb_timer_pkg::MODE_MEASURE: state_ff <= arb_timer_pkg::ST_ARMED;
            arb_timer_pkg::MODE_ARBITRATE: state_ff <= arb_timer_pkg::ST_ARB_WAIT;
            arb_timer_pkg::MODE_IDLE: state_ff <= arb_timer_pkg::ST_IDLE;
            arb_timer_pkg::MODE_RESERVED: state_ff <= arb_timer_pkg::ST_IDLE;
         endcase
      end else if (idle_mode) begin
         state_ff <= arb_timer_pkg::ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         cnt_ff <= arb_timer_pkg::CNT_RESET;
      end else if (cnt_clear && (idle_mode || wr_ctrl || running)) begin
         cnt_ff <= arb_timer_pkg::CNT_RESET;
      end else if (tick_cnt) begin
         cnt_ff <= cnt_ff + arb_timer_pkg::CNT_ONE; // wraps through zero
      end
   end

   assign evt.ovf = tick_cnt && !cnt_clear && cnt_ff == arb_timer_pkg::CNT_MAX;
   assign evt.done = state_ff == arb_timer_pkg::ST_COUNT && !ctrl_ff.clk_sel && rx_fall && !wr_ctrl;
   assign evt.lost = sample_hit && !rx_lvl_ff && !tx_rise && !arb_abort;

   // sample once per restart; seen-low marks a legitimate dominant bit
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         sampled_ff <= 1'b0;
         low_seen_ff <= 1'b0;
      end else if (cnt_clear) begin
         sampled_ff <= 1'b0;
         low_seen_ff <= 1'b0;
      end else if (state_ff == arb_timer_pkg::ST_ARB_CNT) begin
         sampled_ff <= sampled_ff || sample_hit;
         low_seen_ff <= low_seen_ff || !rx_lvl_ff;
      end
   end

   // a lost set beats its clear in the same cycle; a control write suppresses ovf and done events
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         ovf_ff <= 1'b0;
         done_ff <= 1'b0;
         lost_ff <= 1'b0;
      end else begin
         ovf_ff <= evt.ovf || (ovf_ff && !wr_ctrl);
         done_ff <= evt.done || (done_ff && !wr_ctrl);
         lost_ff <= evt.lost || (lost_ff && !(wr_ctrl && !i_avs_writedata[arb_timer_pkg::BIT_MODE_HIGH]));
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         sts_ff <= '0;
         mask_ff <= '0;
      end else begin
         sts_ff <= evt | (sts_ff & ~(wr_sts ? i_avs_writedata[arb_timer_pkg::IRQ_W-1:0] : '0));
         if (wr_mask) begin
            mask_ff <= i_avs_writedata[arb_timer_pkg::IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         irq_ff <= 1'b0;
         txd_ff <= 1'b1;
      end else begin
         irq_ff <= |(sts_ff & mask_ff);
         txd_ff <= i_internal_transmit_out || lost_ff;
      end
   end

   assign o_avs_readdata = rdata_ff;
   assign o_avs_waitrequest = wait_ff;
   assign o_irq = irq_ff;
   assign o_txd = txd_ff;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   chk_run_flag: assert property (running |-> !idle_mode && state_ff != arb_timer_pkg::ST_STOP)
      else $error("running flag set outside counting");
   chk_ovf_sticky: assert property (evt.ovf |=> ovf_ff && cnt_ff == arb_timer_pkg::CNT_RESET)
      else $error("overflow not flagged on wrap");
   chk_ctrl_clear: assert property (wr_ctrl |=> cnt_ff == arb_timer_pkg::CNT_RESET && !done_ff)
      else $error("control write did not clear count");
   chk_idle_hold: assert property (idle_mode && !wr_ctrl |=> cnt_ff == arb_timer_pkg::CNT_RESET && !running)
      else $error("idle mode did not hold counter");
   chk_half_rate: assert property (tick_cnt && !cnt_clear && !ctrl_ff.clk_sel && !wr_ctrl |=> !tick_cnt)
      else $error("counter advanced on consecutive cycles");
   chk_meas_done: assert property (evt.done |=> done_ff && state_ff == arb_timer_pkg::ST_STOP)
      else $error("measurement did not finish on second fall");
   chk_break_stop: assert property (state_ff == arb_timer_pkg::ST_COUNT && ctrl_ff.clk_sel && rx_rise
      && !wr_ctrl && !idle_mode |=> state_ff == arb_timer_pkg::ST_STOP ##1 ($past(wr_ctrl) || $stable(cnt_ff)))
      else $error("break measurement did not stop on rise");
   chk_low_start: assert property (state_ff == arb_timer_pkg::ST_ARMED && ctrl_ff.clk_sel && !rx_lvl_ff
      && !wr_ctrl && !idle_mode |=> running)
      else $error("low level did not start counter");
   chk_arb_restart: assert property (state_ff == arb_timer_pkg::ST_ARB_CNT && tx_rise |=> cnt_ff == arb_timer_pkg::CNT_RESET)
      else $error("transmit rise did not restart count");
   chk_arb_lost: assert property (evt.lost |=> lost_ff ##1 o_txd)
      else $error("lost arbitration not flagged and forced");
   chk_txd_force: assert property (lost_ff |=> o_txd)
      else $error("transmit pin not forced high");
   chk_arb_abort: assert property (arb_abort && !tx_rise && !wr_ctrl |=> state_ff == arb_timer_pkg::ST_ARB_WAIT)
      else $error("arbitration did not restart after early low");
   chk_lost_clear: assert property (wr_ctrl && !i_avs_writedata[arb_timer_pkg::BIT_MODE_HIGH] && !evt.lost |=> !lost_ff)
      else $error("lost flag not cleared by mode write");
   chk_bus_answer: assert property ((i_avs_read || i_avs_write) && wait_ff |=> !o_avs_waitrequest)
      else $error("bus request not answered in one cycle");

   // counter, state, flag, status, pin, readback, interrupt and synchroniser cross-checks
   chk_count_step: assert property (tick_cnt && !cnt_clear
      |=> cnt_ff == $past(cnt_ff) + arb_timer_pkg::CNT_ONE)
      else $error("counter did not advance by one");
   chk_stop_hold: assert property (!running && !wr_ctrl && !idle_mode |=> $stable(cnt_ff))
      else $error("counter moved while stopped");
   chk_meas_start: assert property (state_ff == arb_timer_pkg::ST_ARMED && !ctrl_ff.clk_sel && rx_fall
      && !wr_ctrl && !idle_mode |=> running)
      else $error("falling edge did not start counter");
   chk_ovf_clear: assert property (wr_ctrl |=> !ovf_ff)
      else $error("control write did not clear overflow");
   chk_lost_hold: assert property (lost_ff && !wr_ctrl |=> lost_ff)
      else $error("lost flag dropped without control write");
   chk_sample_once: assert property (sample_hit |=> !sample_hit)
      else $error("line sampled twice in one bit");
   chk_sts_lost: assert property (evt.lost |=> sts_ff[arb_timer_pkg::IRQ_LOST])
      else $error("lost event not latched in status");
   chk_sts_done: assert property (evt.done |=> sts_ff[arb_timer_pkg::IRQ_DONE])
      else $error("done event not latched in status");
   chk_abort_clear: assert property (arb_abort && !wr_ctrl |=> cnt_ff == arb_timer_pkg::CNT_RESET)
      else $error("early transmit low did not clear count");
   chk_reserved_idle: assert property (ctrl_ff.mode == arb_timer_pkg::MODE_RESERVED && !wr_ctrl
      |=> state_ff == arb_timer_pkg::ST_IDLE && cnt_ff == arb_timer_pkg::CNT_RESET)
      else $error("reserved mode did not act as idle");
   chk_txd_follow: assert property (!lost_ff |=> o_txd == $past(i_internal_transmit_out))
      else $error("transmit pin does not follow transmitter");
   chk_rd_count: assert property (acc && i_avs_read && i_avs_address == arb_timer_pkg::OFS_COUNT
      |-> o_avs_readdata[7:0] == $past(cnt_ff[7:0]))
      else $error("count register read wrong value");
   chk_rd_flags: assert property (acc && i_avs_read && i_avs_address == arb_timer_pkg::OFS_CONTROL
      |-> o_avs_readdata[arb_timer_pkg::BIT_RUN] == $past(running)
      && o_avs_readdata[arb_timer_pkg::BIT_MSB] == $past(cnt_ff[CNT_W-1]))
      else $error("control register read wrong flags");
   chk_irq_on: assert property (|(sts_ff & mask_ff) |=> o_irq)
      else $error("interrupt not raised for unmasked status");
   chk_irq_off: assert property (!(|(sts_ff & mask_ff)) |=> !o_irq)
      else $error("interrupt raised without unmasked status");
   chk_wait_idle: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
      else $error("waitrequest low without a request");
   chk_sync_agree: assert property (rx_s2_ff != rx_s3_ff |=> $stable(rx_lvl_ff))
      else $error("receive level changed before stages agreed");

   cov_meas_done: cover property (evt.done);
   cov_arb_lost: cover property (evt.lost ##1 lost_ff);
   cov_overflow: cover property (evt.ovf);
   cov_irq: cover property (o_irq);
   cov_break_stop: cover property (state_ff == arb_timer_pkg::ST_COUNT && ctrl_ff.clk_sel && rx_rise);
endmodule

// >>> inc/arb_timer_pkg.sv
// constants, register map and carrier types for the serial line arbiter timer
package arb_timer_pkg;
   localparam int CNT_W = 9;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   // word-aligned byte offsets
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h0C;
   // arbiter_control_reg bit positions
   localparam int BIT_MODE_HIGH = 7;
   localparam int BIT_MODE_LOW = 6;
   localparam int BIT_LOST = 5;
   localparam int BIT_CLK_SEL = 4;
   localparam int BIT_DONE = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_OVF = 1;
   localparam int BIT_MSB = 0;
   // irq status / mask bit positions
   localparam int IRQ_DONE = 0;
   localparam int IRQ_LOST = 1;
   localparam int IRQ_OVF = 2;
   localparam int IRQ_W = 3;
   // arbitration sample points
   localparam logic [CNT_W-1:0] SAMPLE_BUS_CLK = 9'h038;
   localparam logic [CNT_W-1:0] SAMPLE_PRESC_CLK = 9'h008;
   localparam logic [CNT_W-1:0] CNT_RESET = 9'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
   localparam logic [CNT_W-1:0] CNT_MAX = 9'h1FF;

   typedef enum logic [1:0] {
      MODE_IDLE = 2'b00,
      MODE_MEASURE = 2'b01,
      MODE_ARBITRATE = 2'b10,
      MODE_RESERVED = 2'b11
   } mode_t;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_ARMED = 6'b000010,
      ST_COUNT = 6'b000100,
      ST_STOP = 6'b001000,
      ST_ARB_WAIT = 6'b010000,
      ST_ARB_CNT = 6'b100000
   } state_t;

   typedef struct packed {
      mode_t mode;
      logic clk_sel;
   } ctrl_t;

   typedef struct packed {
      logic ovf;
      logic lost;
      logic done;
   } events_t;
endpackage

// >>> test/line_node.sv
// model of another node on the shared serial line
`timescale 1ns/1ps
module line_node (
   input wire logic i_txd,
   input wire logic i_pull_low,
   output logic o_rxd
);
   // wired-and with pull-up: any node driving low is dominant
   assign o_rxd = i_txd & ~i_pull_low;
endmodule

// >>> test/tb.sv
// self-checking testbench for the serial line arbiter timer
`timescale 1ns/1ps
module tb;
   localparam logic [4:0] A_CTL = arb_timer_pkg::OFS_CONTROL;
   localparam logic [4:0] A_CNT = arb_timer_pkg::OFS_COUNT;
   localparam logic [4:0] A_STS = arb_timer_pkg::OFS_IRQ_STATUS;
   localparam logic [4:0] A_MSK = arb_timer_pkg::OFS_IRQ_MASK;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic tx = 1'b1;
   logic pull = 1'b0;
   logic tick = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic waitreq, rxd, txd, irq;
   logic [7:0] q;
   int bad_count = 0;
   int checks_done = 0;

   always #12.5 sys_clk = ~sys_clk;
   // prescaler pulse every second clock
   always @(posedge sys_clk) tick <= ~tick;

   serial_line_arbiter_timer dut_u (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_avs_address(addr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
      .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_rxd(rxd),
      .i_internal_transmit_out(tx), .i_presc_tick(tick), .o_txd(txd), .o_irq(irq));
   line_node node_u (.i_txd(txd), .i_pull_low(pull), .o_rxd(rxd));

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic give_verdict;
      if (bad_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rng(input logic [7:0] got, input int lo, input int hi);
      checks_done++;
      if ($isunknown(got) || got < lo || got > hi) begin
         bad_count++;
         $display("MISMATCH %0t count %h outside %0d..%0d", $time, got, lo, hi);
      end
   endtask

   // request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      addr <= a;
      wdata <= {24'h0, d};
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge sys_clk);
         n++;
      end while (waitreq !== 1'b0 && n < 20);
      if (n >= 20) begin
         bad_count++;
         $display("MISMATCH %0t bus never answered", $time);
      end
      q = rdata[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic t_reset_map;
      bus(0, A_CTL, 8'h00); chk(q, 8'h00);
      bus(0, A_CNT, 8'h00); chk(q, 8'h00);
      bus(0, 5'h10, 8'h00); chk(q, 8'h00);
      bus(1, A_CNT, 8'hFF); bus(0, A_CNT, 8'h00); chk(q, 8'h00);
      bus(1, A_CTL, 8'hD0); bus(0, A_CTL, 8'h00); chk(q, 8'hD0);
      bus(1, A_CTL, 8'h00);
   endtask

   task automatic t_measure_fall;
      bus(1, A_CTL, 8'h40);
      cyc(4); pull <= 1'b1;
      cyc(4); pull <= 1'b0;
      cyc(36);
      bus(0, A_CTL, 8'h00); chk(q, 8'h44);
      cyc(57); pull <= 1'b1;
      cyc(8);
      bus(0, A_CTL, 8'h00); chk(q, 8'h48);
      bus(0, A_CNT, 8'h00); rng(q, 48, 52);
      bus(1, A_MSK, 8'h01); cyc(2); chk({7'h0, irq}, 8'h01);
      bus(1, A_STS, 8'h01); cyc(2); chk({7'h0, irq}, 8'h00);
      pull <= 1'b0;
      bus(1, A_CTL, 8'h00); bus(0, A_CTL, 8'h00); chk(q, 8'h00);
      bus(0, A_CNT, 8'h00); chk(q, 8'h00);
      bus(1, A_MSK, 8'h00);
   endtask

   task automatic t_measure_low;
      pull <= 1'b1;
      cyc(6);
      bus(1, A_CTL, 8'h50);
      cyc(80);
      bus(0, A_CTL, 8'h00); chk(q, 8'h54);
      pull <= 1'b0;
      cyc(10);
      bus(0, A_CTL, 8'h00); chk(q & 8'hF7, 8'h50);
      bus(0, A_CNT, 8'h00); rng(q, 18, 26);
      bus(1, A_CTL, 8'h00);
   endtask

   // another node dominates the line across the sample point or stays recessive
   task automatic t_arb(input logic [7:0] ctl, input logic lose);
      tx <= 1'b0;
      bus(1, A_CTL, ctl);
      cyc(4); tx <= 1'b1;
      cyc(10); pull <= lose;
      cyc(140); pull <= 1'b0;
      cyc(4);
      bus(0, A_CTL, 8'h00); chk({7'h0, q[5]}, {7'h0, lose});
      tx <= 1'b0;
      cyc(3); chk({7'h0, txd}, {7'h0, lose});
      bus(1, A_CTL, 8'h00); cyc(3); chk({7'h0, txd}, 8'h00);
      bus(0, A_CTL, 8'h00); chk(q, 8'h00);
   endtask

   task automatic t_arb_restart;
      tx <= 1'b1;
      cyc(6);
      bus(1, A_CTL, 8'h80);
      // a one-cycle low is filtered by the synchroniser, so no low reaches the line sense
      cyc(4); tx <= 1'b0;
      cyc(1); tx <= 1'b1;
      cyc(40); tx <= 1'b0;
      cyc(2);
      bus(0, A_CNT, 8'h00); chk(q, 8'h00);
      tx <= 1'b1;
      cyc(20);
      bus(0, A_CNT, 8'h00); rng(q, 9, 14);
      bus(1, A_CTL, 8'h00);
   endtask

   task automatic t_overflow;
      bus(1, A_CTL, 8'h40);
      cyc(4); pull <= 1'b1;
      cyc(4); pull <= 1'b0;
      cyc(600);
      bus(0, A_CTL, 8'h00); chk(q, 8'h45);
      cyc(500);
      bus(0, A_CTL, 8'h00); chk(q, 8'h46);
      bus(0, A_STS, 8'h00); chk(q & 8'h04, 8'h04);
      bus(1, A_CTL, 8'h40); bus(0, A_CTL, 8'h00); chk(q, 8'h40);
      bus(0, A_CNT, 8'h00); chk(q, 8'h00);
      bus(1, A_STS, 8'h07);
      bus(0, A_STS, 8'h00); chk(q, 8'h00);
      bus(1, A_CTL, 8'h00);
   endtask

   initial begin
      cyc(3);
      rst_n <= 1'b1;
      t_reset_map();
      t_measure_fall();
      t_measure_low();
      t_arb(8'h80, 1'b1);
      t_arb(8'h90, 1'b1);
      t_arb(8'h80, 1'b0);
      t_arb_restart();
      t_overflow();
      give_verdict();
   end

   // whole run needs about 2000 cycles
   initial begin
      cyc(20000);
      bad_count++;
      $display("MISMATCH %0t run did not complete", $time);
      give_verdict();
   end
endmodule
